// File: psp_host_bus.sv
`timescale 1ns/1ps
module psp_host_bus (
  input wire logic core_clk,
  input wire logic host_en,
  input wire logic [35:0] host_word,
  input wire logic dq_oe,
  input wire logic [31:0] dq_out,
  input wire logic parity_lines_oe,
  input wire logic [3:0] parity_lines_out,
  output logic [35:0] bus_word,
  output logic clash
);
  logic [35:0] last_reg;
  // A released bus shows the inverse of its last level
  assign bus_word = dq_oe ? {parity_lines_out, dq_out} : host_en ? host_word : ~last_reg;
  // Overlap is judged just before each edge, where the bus is sampled
  always_ff @(posedge core_clk)
  begin
    clash <= host_en & (dq_oe | parity_lines_oe);
  end
  always_ff @(posedge core_clk)
  begin
    last_reg <= bus_word;
  end
endmodule // psp_host_bus

// File: psp_pkg.sv
package psp_pkg;
  // Array geometry
  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int WORD_W = 36;
  localparam int DEPTH = 131072;
  localparam int BURST_W = 2;
  // Burst order strap level for interleaved order
  localparam logic BURST_INTERLEAVED = 1'b1;
  // Reset values of control and output state, and the burst counter step
  localparam logic [ADDR_W-1:0] ADDR_RESET = 17'h00000;
  localparam logic [WORD_W-1:0] WORD_RESET = 36'h000000000;
  localparam logic [LANES-1:0] MASK_RESET = 4'hF;
  localparam logic [BURST_W-1:0] COUNT_RESET = 2'h0;
  localparam logic [BURST_W-1:0] COUNT_STEP = 2'h1;
  localparam logic OE_N_RESET = 1'b1;
  localparam logic STRAP_RESET = 1'b1;
endpackage

// File: psp_sram_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// - All synchronous inputs are captured into registers on the rising clock edge.
// - Read data leaves through output registers clocked on the rising edge.
// - High clock gate ignores edges and freezes pipeline, burst counter and read data; output enable and strap sync still run; no deselect.
// - A 17-bit address selects one of 131,072 words of 36 bits.
// - Low lane write selects enable their byte and parity bit during writes.
// - Advance high with clock gate low steps the burst address counter.
// - Advance low loads the presented address as a new access.
// - Data drivers are three-stated during the data phase of every write.
// - Three chip selects select the device; async output enable gates drivers.
// - Any mix of reads and writes runs back to back, no wait states.
// - Selected only when select one low, select two high, select three low.
// - Burst order strap: high interleaved, low linear; static during operation.
// - Outputs float two clocks after a deselect is sampled, the same delay as read data.
module psp_sram_port (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [psp_pkg::ADDR_W-1:0] addr,
  input wire logic write_n,
  input wire logic [psp_pkg::LANES-1:0] lane_write_mask_n,
  input wire logic select_one_n,
  input wire logic select_two,
  input wire logic select_three_n,
  input wire logic advance_or_load,
  input wire logic clock_gate_n,
  input wire logic output_enable_n,
  input wire logic burst_order,
  input wire logic [psp_pkg::DATA_W-1:0] dq_in,
  output logic [psp_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [psp_pkg::LANES-1:0] parity_lines_in,
  output logic [psp_pkg::LANES-1:0] parity_lines_out,
  output logic parity_lines_oe
);

  function automatic logic chip_selected(input logic s1_n, input logic s2, input logic s3_n);
    chip_selected = !s1_n && s2 && !s3_n;
  endfunction

  logic s1_valid_reg, s1_write_reg;
  logic [psp_pkg::ADDR_W-1:0] s1_addr_reg;
  logic [psp_pkg::LANES-1:0] s1_mask_n_reg;
  logic [psp_pkg::BURST_W-1:0] start_low_reg, count_reg;
  logic s2_valid_reg, s2_write_reg;
  logic [psp_pkg::ADDR_W-1:0] s2_addr_reg;
  logic [psp_pkg::LANES-1:0] s2_mask_n_reg;
  logic s3_write_reg;
  logic [psp_pkg::ADDR_W-1:0] s3_addr_reg;
  logic [psp_pkg::LANES-1:0] s3_mask_n_reg;
  logic rd_active_reg;
  logic [psp_pkg::WORD_W-1:0] dout_reg;
  logic oe_reg;
  logic oe_n_meta_reg, oe_n_sync_reg;
  logic strap_meta_reg, strap_sync_reg, order_reg;

  // Input side decode
  wire en = !clock_gate_n;
  wire sel_now = chip_selected(select_one_n, select_two, select_three_n);
  wire load = !advance_or_load;
  wire [psp_pkg::BURST_W-1:0] count_next = count_reg + psp_pkg::COUNT_STEP;
  wire [psp_pkg::BURST_W-1:0] burst_low = (order_reg == psp_pkg::BURST_INTERLEAVED) ?
    (start_low_reg ^ count_next) : (start_low_reg + count_next);
  wire [psp_pkg::ADDR_W-1:0] s1_addr_next = load ? addr :
    {s1_addr_reg[psp_pkg::ADDR_W-1:psp_pkg::BURST_W], burst_low};
  wire s1_valid_next = load ? sel_now : s1_valid_reg;
  wire s1_write_next = load ? !write_n : s1_write_reg;
  wire s2_read = s2_valid_reg && !s2_write_reg;
  wire fwd_hit = s3_write_reg && (s3_addr_reg == s2_addr_reg);
  wire oe_next = (en ? s2_read : rd_active_reg) && !oe_n_sync_reg;

  logic [psp_pkg::WORD_W-1:0] wr_word, rd_raw, rd_word;

  // One storage array per byte lane; each lane holds a byte and its parity bit
  genvar gi;
  generate
    for (gi = 0; gi < psp_pkg::LANES; gi++)
    begin : g_lane
      logic [psp_pkg::LANE_W-1:0] mem_lane [psp_pkg::DEPTH];
      assign wr_word[gi*psp_pkg::LANE_W +: psp_pkg::LANE_W] =
        {parity_lines_in[gi], dq_in[gi*8 +: 8]};
      assign rd_raw[gi*psp_pkg::LANE_W +: psp_pkg::LANE_W] = mem_lane[s2_addr_reg];
      // A write landing on the same edge as the read is forwarded lane by lane
      assign rd_word[gi*psp_pkg::LANE_W +: psp_pkg::LANE_W] = (fwd_hit && !s3_mask_n_reg[gi]) ?
        wr_word[gi*psp_pkg::LANE_W +: psp_pkg::LANE_W] :
        rd_raw[gi*psp_pkg::LANE_W +: psp_pkg::LANE_W];
      always_ff @(posedge core_clk)
      begin
        if (en && s3_write_reg && !s3_mask_n_reg[gi])
          mem_lane[s3_addr_reg] <= wr_word[gi*psp_pkg::LANE_W +: psp_pkg::LANE_W];
      end
      assign dq_out[gi*8 +: 8] = dout_reg[gi*psp_pkg::LANE_W +: 8];
      assign parity_lines_out[gi] = dout_reg[gi*psp_pkg::LANE_W + 8];
    end
  endgenerate

  assign dq_oe = oe_reg;
  assign parity_lines_oe = oe_reg;

  // Asynchronous output enable and static strap cross into the clock domain
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oe_n_meta_reg <= psp_pkg::OE_N_RESET;
      oe_n_sync_reg <= psp_pkg::OE_N_RESET;
      strap_meta_reg <= psp_pkg::STRAP_RESET;
      strap_sync_reg <= psp_pkg::STRAP_RESET;
    end
    else
    begin
      oe_n_meta_reg <= output_enable_n;
      oe_n_sync_reg <= oe_n_meta_reg;
      strap_meta_reg <= burst_order;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Burst order is taken from the strap; it is expected not to move
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      order_reg <= psp_pkg::STRAP_RESET;
    else
      order_reg <= strap_sync_reg;
  end

  // Stage 1: command capture with burst counter
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_valid_reg <= 1'b0;
      s1_write_reg <= 1'b0;
      s1_addr_reg <= psp_pkg::ADDR_RESET;
      s1_mask_n_reg <= psp_pkg::MASK_RESET;
      start_low_reg <= psp_pkg::COUNT_RESET;
      count_reg <= psp_pkg::COUNT_RESET;
    end
    else if (en)
    begin
      s1_valid_reg <= s1_valid_next;
      s1_write_reg <= s1_write_next;
      s1_addr_reg <= s1_addr_next;
      s1_mask_n_reg <= lane_write_mask_n;
      start_low_reg <= load ? addr[psp_pkg::BURST_W-1:0] : start_low_reg;
      count_reg <= load ? psp_pkg::COUNT_RESET : count_next;
    end
  end

  // Stages 2 and 3: address pipe and pending write
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s2_valid_reg <= 1'b0;
      s2_write_reg <= 1'b0;
      s2_addr_reg <= psp_pkg::ADDR_RESET;
      s2_mask_n_reg <= psp_pkg::MASK_RESET;
      s3_write_reg <= 1'b0;
      s3_addr_reg <= psp_pkg::ADDR_RESET;
      s3_mask_n_reg <= psp_pkg::MASK_RESET;
    end
    else if (en)
    begin
      s2_valid_reg <= s1_valid_reg;
      s2_write_reg <= s1_write_reg;
      s2_addr_reg <= s1_addr_reg;
      s2_mask_n_reg <= s1_mask_n_reg;
      s3_write_reg <= s2_valid_reg && s2_write_reg;
      s3_addr_reg <= s2_addr_reg;
      s3_mask_n_reg <= s2_mask_n_reg;
    end
  end

  // Output register and driver enable
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dout_reg <= psp_pkg::WORD_RESET;
      rd_active_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else
    begin
      oe_reg <= oe_next;
      if (en)
      begin
        rd_active_reg <= s2_read;
        if (s2_read)
          dout_reg <= rd_word;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_gate_freeze: assert property (clock_gate_n |=> $stable(dout_reg) && $stable(s1_addr_reg))
    else $error("state moved while clock gated");
  a_addr_load: assert property (en && load |=> s1_addr_reg == $past(addr))
    else $error("address not loaded");
  a_burst_linear: assert property ((en && !load && order_reg != psp_pkg::BURST_INTERLEAVED)
    |=> s1_addr_reg[1:0] == $past(s1_addr_reg[1:0]) + 2'h1)
    else $error("linear burst step wrong");
  a_select_decode: assert property (en && load
    |=> s1_valid_reg == $past(!select_one_n && select_two && !select_three_n))
    else $error("chip select decode wrong");
  a_write_float: assert property ((en && s1_valid_reg && s1_write_reg) ##1 en |=> !dq_oe)
    else $error("driver on during write data");
  a_desel_float: assert property ((en && !s2_valid_reg) |=> !dq_oe && !parity_lines_oe)
    else $error("driver on while deselected");
  a_read_data: assert property ((en && s1_valid_reg && !s1_write_reg) ##1 en
    |=> {parity_lines_out[0], dq_out[7:0]} == $past(rd_word[8:0])
    && {parity_lines_out[3], dq_out[31:24]} == $past(rd_word[35:27]))
    else $error("read data not registered");
  a_lane_keep: assert property (fwd_hit && s3_mask_n_reg[0] |-> rd_word[8:0] == rd_raw[8:0])
    else $error("masked lane altered");
  a_fwd_data: assert property ((en && s2_read && fwd_hit && !s3_mask_n_reg[0])
    |=> {parity_lines_out[0], dq_out[7:0]} == $past({parity_lines_in[0], dq_in[7:0]}))
    else $error("written lane not forwarded");
  a_read_drive: assert property ((en && s2_read && !oe_n_sync_reg)
    |=> dq_oe && parity_lines_oe)
    else $error("read not driven");

endmodule // psp_sram_port

// File: psp_tb.sv
`timescale 1ns/1ps
module testbench;
  typedef struct {int k; logic [16:0] a; logic [3:0] m; logic [35:0] d;} psp_cmd_t;
  logic core_clk = 1'h0, rst_n = 1'h0, write_n = 1'h1, advance_or_load = 1'h0;
  logic select_one_n = 1'h1, select_two = 1'h0, select_three_n = 1'h1;
  logic clock_gate_n = 1'h0, output_enable_n = 1'h0, burst_order = 1'h1;
  logic host_en = 1'h0, gated = 1'h0, dq_oe, parity_lines_oe, clash, rd;
  logic [16:0] addr = 17'h00000, start;
  logic [3:0] lane_write_mask_n = 4'hF, parity_lines_out;
  logic [31:0] dq_out;
  logic [35:0] host_word = 36'h000000000, bus_word, keep;
  logic [36:0] seen;
  logic [35:0] mem [131072];
  psp_cmd_t q [3];
  int kind, cnt, n_errors = 0, checked = 0, cycles = 0;
  always #10 core_clk = ~core_clk;
  psp_sram_port dut_u (.core_clk, .rst_n, .addr, .write_n, .lane_write_mask_n, .select_one_n,
    .select_two, .select_three_n, .advance_or_load, .clock_gate_n, .output_enable_n, .burst_order,
    .dq_in(bus_word[31:0]), .dq_out, .dq_oe, .parity_lines_in(bus_word[35:32]),
    .parity_lines_out, .parity_lines_oe);
  psp_host_bus host_u (.core_clk, .host_en, .host_word, .dq_oe, .dq_out, .parity_lines_oe,
    .parity_lines_out, .bus_word, .clash);
  task automatic final_report();
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [36:0] got, input logic [36:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic step(input logic g, v, wn, input logic [2:0] s, input logic [16:0] a,
    input logic [3:0] m, input logic [35:0] d);
    @(negedge core_clk);
    rd = q[2].k == 1 && !output_enable_n;
    chk(37'(clash), 37'h0);
    if (gated)
      chk({dq_oe, parity_lines_out, dq_out}, seen);
    else
    begin
      keep = {q[2].m, {8{q[2].m[3]}}, {8{q[2].m[2]}}, {8{q[2].m[1]}}, {8{q[2].m[0]}}};
      host_en = q[2].k == 2;
      host_word = q[2].d;
      if (host_en)
        mem[q[2].a] = (mem[q[2].a] & keep) | (q[2].d & ~keep);
      chk({35'h0, dq_oe, parity_lines_oe}, {35'h0, rd, rd});
      if (rd)
        chk({1'h1, parity_lines_out, dq_out}, {1'h1, mem[q[2].a]});
      q[2] = q[1];
      q[1] = q[0];
    end
    seen = {dq_oe, parity_lines_out, dq_out};
    gated = g;
    clock_gate_n = g;
    if (!g)
    begin
      if (!v)
      begin
        start = a;
        cnt = 0;
        kind = s != 3'h2 ? 0 : wn ? 1 : 2;
      end
      else
        cnt++;
      q[0] = '{kind, burst_order ? {start[16:2], start[1:0] ^ 2'(cnt)} :
        {start[16:2], start[1:0] + 2'(cnt)}, m, d};
      {select_one_n, select_two, select_three_n} = s;
      advance_or_load = v;
      write_n = wn;
      addr = a;
      lane_write_mask_n = m;
    end
  endtask
  task automatic wr(input logic [16:0] a, input logic [3:0] m, input logic [35:0] d);
    step(1'h0, 1'h0, 1'h0, 3'h2, a, m, d);
  endtask
  task automatic rdc(input logic [16:0] a);
    step(1'h0, 1'h0, 1'h1, 3'h2, a, 4'hF, 36'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) step(1'h0, 1'h0, 1'h1, 3'h7, 17'h00000, 4'hF, 36'h0);
  endtask
  task automatic adv3();
    for (int i = 1; i < 4; i++) step(1'h0, 1'h1, 1'h1, 3'h0, 17'h0, 4'h0, 36'(i) * 36'h111111111);
  endtask
  task automatic do_reset(input logic strap);
    @(negedge core_clk);
    rst_n = 1'h0;
    host_en = 1'h0;
    gated = 1'h0;
    clock_gate_n = 1'h0;
    burst_order = strap;
    foreach (q[i]) q[i].k = 0;
    repeat (2) @(negedge core_clk);
    chk({35'h0, dq_oe, parity_lines_oe}, 37'h0);
    rst_n = 1'h1;
    idle(3);
  endtask
  task automatic t_burst();
    wr(17'h00101, 4'h0, 36'h0F0F0F0F0);
    adv3();
    rdc(17'h00101);
    adv3();
    idle(3);
  endtask
  initial
  begin
    do_reset(1'h1);
    wr(17'h1FFFF, 4'h0, 36'h9A5A5A5A5);
    rdc(17'h1FFFF);
    wr(17'h00000, 4'h0, 36'h123456789);
    wr(17'h1FFFF, 4'h5, 36'h6FEDCBA98);
    rdc(17'h1FFFF);
    rdc(17'h00000);
    wr(17'h00040, 4'h0, 36'hABCDEF012);
    idle(3);
    t_burst();
    for (int s = 0; s < 8; s++) step(1'h0, 1'h0, 1'h1, 3'(s), 17'h00040, 4'hF, 36'h0);
    wr(17'h00041, 4'h0, 36'h5C3A69E1B);
    rdc(17'h00040);
    repeat (3) step(1'h1, 1'h0, 1'h0, 3'h2, 17'h0, 4'h0, 36'h0);
    rdc(17'h00041);
    idle(3);
    output_enable_n = 1'h1;
    idle(3);
    rdc(17'h00040);
    idle(3);
    output_enable_n = 1'h0;
    idle(3);
    do_reset(1'h0);
    t_burst();
    final_report();
  end
endmodule // testbench
